// ===== phss_pkg.sv
// Shared constants, enumerations and carriers of the purge and heating sequencer
package phss_pkg;

  // System clock and time base
  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned PURGE_TIME_MIN = 6;
  localparam int unsigned PERIOD_TIME_H = 24;
  localparam int unsigned WARM_HOLD_MIN = 4;
  localparam int unsigned STARTUP_TIME_S = 2;
  localparam int unsigned PURGE_TIME_S = PURGE_TIME_MIN * 60;
  localparam int unsigned PERIOD_TIME_S = PERIOD_TIME_H * 3600;
  localparam int unsigned WARM_HOLD_S = WARM_HOLD_MIN * 60;

  // Register word addresses
  localparam logic [15:0] ADDR_CONFIG = 16'h0300;
  localparam logic [15:0] ADDR_COMMAND = 16'h0301;
  localparam logic [15:0] ADDR_STATUS = 16'h0302;
  localparam logic [15:0] ADDR_EXT_TEMP = 16'h0334;

  // Configuration word fields
  localparam int unsigned CFG_LED_EN_BIT = 0;
  localparam int unsigned CFG_COND_EN_BIT = 1;
  localparam int unsigned CFG_PROBE_EN_BIT = 2;
  // Command word fields
  localparam int unsigned CMD_PURGE_BIT = 0;
  localparam int unsigned CMD_EXT_CLR_BIT = 1;

  // Values after reset
  localparam logic CFG_LED_EN_RST = 1'b1;
  localparam logic CFG_COND_EN_RST = 1'b0;
  localparam logic CFG_PROBE_EN_RST = 1'b0;
  localparam logic [15:0] EXT_TEMP_RST = 16'h0000;

  // Fitted sensor variant
  typedef enum logic [1:0] {
    VAR_PURGE_ONCE = 2'b00,
    VAR_PURGE_DAILY = 2'b01,
    VAR_OIL = 2'b10
  } phss_variant_t;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_IDLE = 2'b01,
    ST_PURGE = 2'b10
  } phss_state_t;

  // Decoded register access from the Modbus front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } phss_mb_req_t;

  // Whole state of the sequencer
  typedef struct packed {
    phss_state_t state;
    logic [31:0] pre_cnt;
    logic [31:0] sec_tmr;
    logic [31:0] period_tmr;
    logic [31:0] hold_tmr;
    logic blink;
    logic contact_prev;
    logic led_en;
    logic cond_en;
    logic probe_en;
    logic ext_valid;
    logic [15:0] ext_temp;
    logic warm_prev;
    logic purge_heat;
    logic sensor_warm;
    logic probe_heat;
    logic heat_boost;
    logic meas_valid;
    logic dp_valid;
    logic temp_valid;
    logic hold_out;
    logic led_green;
    logic led_red;
    logic rd_valid;
    logic [15:0] rdata;
  } phss_st_t;

endpackage : phss_pkg

// ===== phss_seq.sv
// Purge, warming and status LED sequencer with its Modbus register file
`timescale 1ns/100ps
`default_nettype none

module phss_seq #(
  parameter int unsigned CLK_PER_SEC = phss_pkg::SYS_CLK_HZ,
  parameter int unsigned PURGE_S = phss_pkg::PURGE_TIME_S,
  parameter int unsigned PERIOD_S = phss_pkg::PERIOD_TIME_S,
  parameter int unsigned WARM_HOLD_SEC = phss_pkg::WARM_HOLD_S,
  parameter int unsigned STARTUP_S = phss_pkg::STARTUP_TIME_S,
  parameter logic COND_EN_RST = phss_pkg::CFG_COND_EN_RST
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Modbus register access
  input wire phss_pkg::phss_mb_req_t mb_req,
  input wire logic mb_active,
  output logic mb_rd_valid,
  output logic [15:0] mb_rdata,
  // Module condition
  input wire phss_pkg::phss_variant_t variant,
  input wire logic error_in,
  input wire logic supply_ok,
  input wire logic purge_contact,
  input wire logic warm_needed,
  input wire logic dewpoint_near,
  // Heater controls
  output logic purge_heat_on,
  output logic sensor_warm_on,
  output logic probe_heat_on,
  output logic heat_boost,
  // Output availability
  output logic meas_valid,
  output logic dp_valid,
  output logic temp_valid,
  output logic hold_outputs,
  // Status LED
  output logic led_green,
  output logic led_red
);

  phss_pkg::phss_st_t s_q;
  phss_pkg::phss_st_t s_d;
  logic tick;
  logic start_req;
  logic can_purge;
  logic period_due;
  logic warming;

  always_comb
  begin
    s_d = s_q;
    tick = (s_q.pre_cnt == 32'(CLK_PER_SEC - 1));
    can_purge = (variant != phss_pkg::VAR_OIL);
    period_due = tick && (variant == phss_pkg::VAR_PURGE_DAILY) &&
                 (s_q.period_tmr == 32'(PERIOD_S - 1));
    start_req = 1'b0;
    s_d.pre_cnt = tick ? 32'h0000_0000 : s_q.pre_cnt + 32'h0000_0001;
    if (tick)
    begin
      s_d.blink = ~s_q.blink;
    end
    s_d.contact_prev = purge_contact;

    // Register writes
    if (mb_req.wr)
    begin
      case (mb_req.addr)
        phss_pkg::ADDR_CONFIG:
        begin
          s_d.led_en = mb_req.wdata[phss_pkg::CFG_LED_EN_BIT];
          s_d.cond_en = mb_req.wdata[phss_pkg::CFG_COND_EN_BIT];
          s_d.probe_en = mb_req.wdata[phss_pkg::CFG_PROBE_EN_BIT];
        end
        phss_pkg::ADDR_COMMAND:
        begin
          start_req = mb_req.wdata[phss_pkg::CMD_PURGE_BIT];
          if (mb_req.wdata[phss_pkg::CMD_EXT_CLR_BIT])
          begin
            s_d.ext_valid = 1'b0;
          end
        end
        phss_pkg::ADDR_EXT_TEMP:
        begin
          s_d.ext_temp = mb_req.wdata;
          s_d.ext_valid = 1'b1;
        end
        default:
        begin
          s_d.ext_valid = s_q.ext_valid;
        end
      endcase
    end
    if (purge_contact && !s_q.contact_prev)
    begin
      start_req = 1'b1;
    end

    // Register reads, one cycle later, unmapped reads as zero
    s_d.rd_valid = mb_req.rd;
    if (mb_req.rd)
    begin
      case (mb_req.addr)
        phss_pkg::ADDR_CONFIG:
          s_d.rdata = {13'h0000, s_q.probe_en, s_q.cond_en, s_q.led_en};
        phss_pkg::ADDR_STATUS:
          s_d.rdata = {8'h00, s_q.ext_valid, s_q.temp_valid, s_q.dp_valid, s_q.meas_valid,
                       s_q.probe_heat, s_q.sensor_warm, s_q.purge_heat, error_in};
        phss_pkg::ADDR_EXT_TEMP:
          s_d.rdata = s_q.ext_temp;
        default:
          s_d.rdata = 16'h0000;
      endcase
    end

    // Daily schedule runs from the end of power-up
    if (s_q.state != phss_pkg::ST_BOOT && tick)
    begin
      s_d.period_tmr = period_due ? 32'h0000_0000 : s_q.period_tmr + 32'h0000_0001;
    end

    // Sequencer; the automatic schedule has no disable bit
    case (s_q.state)
      phss_pkg::ST_BOOT:
      begin
        if (tick)
        begin
          s_d.sec_tmr = s_q.sec_tmr + 32'h0000_0001;
        end
        if (tick && s_q.sec_tmr == 32'(STARTUP_S - 1))
        begin
          s_d.sec_tmr = 32'h0000_0000;
          s_d.state = can_purge ? phss_pkg::ST_PURGE : phss_pkg::ST_IDLE;
        end
      end
      phss_pkg::ST_IDLE:
      begin
        if ((start_req || period_due) && can_purge)
        begin
          s_d.sec_tmr = 32'h0000_0000;
          s_d.state = phss_pkg::ST_PURGE;
        end
      end
      phss_pkg::ST_PURGE:
      begin
        // New requests fall through unused here
        if (tick)
        begin
          s_d.sec_tmr = s_q.sec_tmr + 32'h0000_0001;
        end
        if (tick && s_q.sec_tmr == 32'(PURGE_S - 1))
        begin
          s_d.sec_tmr = 32'h0000_0000;
          s_d.state = phss_pkg::ST_IDLE;
        end
      end
      default:
      begin
        s_d.state = phss_pkg::ST_IDLE;
      end
    endcase

    // Heaters
    s_d.purge_heat = (s_q.state == phss_pkg::ST_PURGE);
    s_d.sensor_warm = s_q.cond_en && warm_needed && (s_q.state == phss_pkg::ST_IDLE);
    s_d.probe_heat = s_q.cond_en && s_q.probe_en && supply_ok;
    s_d.heat_boost = s_q.cond_en && s_q.probe_en && supply_ok && dewpoint_near;

    // Warming hold-off after the sensor warming stops
    warming = s_q.sensor_warm || s_q.probe_heat;
    s_d.warm_prev = s_q.sensor_warm;
    if (s_q.sensor_warm)
    begin
      s_d.hold_tmr = 32'h0000_0000;
    end
    else if (s_q.warm_prev)
    begin
      s_d.hold_tmr = 32'(WARM_HOLD_SEC);
    end
    else if (tick && s_q.hold_tmr != 32'h0000_0000)
    begin
      s_d.hold_tmr = s_q.hold_tmr - 32'h0000_0001;
    end

    // Output availability
    s_d.meas_valid = (s_q.state == phss_pkg::ST_IDLE);
    s_d.hold_out = (s_q.state != phss_pkg::ST_IDLE);
    s_d.dp_valid = (s_q.state == phss_pkg::ST_IDLE);
    s_d.temp_valid = (s_q.state == phss_pkg::ST_IDLE) &&
                     (s_q.ext_valid || (!warming && !s_q.warm_prev &&
                      s_q.hold_tmr == 32'h0000_0000));

    // Status LED
    if (!s_q.led_en)
    begin
      s_d.led_green = 1'b0;
      s_d.led_red = 1'b0;
    end
    else if (error_in)
    begin
      s_d.led_green = 1'b0;
      s_d.led_red = 1'b1;
    end
    else if (s_q.state == phss_pkg::ST_BOOT || mb_active)
    begin
      s_d.led_green = s_q.blink;
      s_d.led_red = 1'b0;
    end
    else
    begin
      s_d.led_green = 1'b1;
      s_d.led_red = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      s_q <= '0;
      s_q.state <= phss_pkg::ST_BOOT;
      s_q.led_en <= phss_pkg::CFG_LED_EN_RST;
      s_q.cond_en <= COND_EN_RST;
      s_q.probe_en <= phss_pkg::CFG_PROBE_EN_RST;
      s_q.ext_temp <= phss_pkg::EXT_TEMP_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign mb_rd_valid = s_q.rd_valid;
  assign mb_rdata = s_q.rdata;
  assign purge_heat_on = s_q.purge_heat;
  assign sensor_warm_on = s_q.sensor_warm;
  assign probe_heat_on = s_q.probe_heat;
  assign heat_boost = s_q.heat_boost;
  assign meas_valid = s_q.meas_valid;
  assign dp_valid = s_q.dp_valid;
  assign temp_valid = s_q.temp_valid;
  assign hold_outputs = s_q.hold_out;
  assign led_green = s_q.led_green;
  assign led_red = s_q.led_red;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  a_led_dark: assert property (!s_q.led_en |=> !led_green && !led_red)
    else $error("LED lit while disabled");
  a_led_steady: assert property (s_q.led_en && !error_in && !mb_active && s_q.state != phss_pkg::ST_BOOT
    |=> led_green && !led_red)
    else $error("LED not steady green when ready");
  a_led_blink: assert property (s_q.led_en && !error_in && mb_active && tick
    ##1 s_q.led_en && !error_in && mb_active |=> led_green != $past(led_green))
    else $error("LED not blinking during traffic");
  a_led_red: assert property (s_q.led_en && error_in |=> led_red && !led_green)
    else $error("LED not red on error");
  a_led_cfg: assert property (mb_req.wr && mb_req.addr == phss_pkg::ADDR_CONFIG
    |=> s_q.led_en == $past(mb_req.wdata[phss_pkg::CFG_LED_EN_BIT]))
    else $error("LED enable not stored");
  a_purge_len: assert property (s_q.state == phss_pkg::ST_PURGE |-> s_q.sec_tmr < PURGE_S)
    else $error("Purge overran its time");
  a_purge_unavail: assert property (s_q.state == phss_pkg::ST_PURGE |=> !meas_valid && purge_heat_on)
    else $error("Measurement valid during purge");
  a_boot_purge: assert property (s_q.state == phss_pkg::ST_BOOT && s_d.state == phss_pkg::ST_IDLE
    |-> variant == phss_pkg::VAR_OIL)
    else $error("Start-up purge skipped");
  a_daily_purge: assert property (s_q.state == phss_pkg::ST_IDLE && period_due
    |=> s_q.state == phss_pkg::ST_PURGE || $past(variant) == phss_pkg::VAR_OIL)
    else $error("Daily purge missed");
  a_manual_purge: assert property (s_q.state == phss_pkg::ST_IDLE && start_req && can_purge
    |=> s_q.state == phss_pkg::ST_PURGE ##1 purge_heat_on)
    else $error("Manual purge not started");
  a_no_oil_purge: assert property (s_q.state != phss_pkg::ST_PURGE && s_d.state == phss_pkg::ST_PURGE
    |-> variant != phss_pkg::VAR_OIL)
    else $error("Purge on oil sensor");
  a_warm_hides: assert property (s_q.sensor_warm && !s_q.ext_valid |=> !temp_valid)
    else $error("Temperature valid while warming");
  a_dp_kept: assert property (s_q.state == phss_pkg::ST_IDLE && s_q.sensor_warm |=> dp_valid)
    else $error("Dew point lost during warming");
  a_hold_off: assert property ($fell(s_q.sensor_warm) && !s_q.probe_heat |=>
    s_q.hold_tmr == WARM_HOLD_SEC)
    else $error("Hold-off not loaded");
  a_hold_gate: assert property (s_q.hold_tmr != 32'h0000_0000 && !s_q.ext_valid |=> !temp_valid)
    else $error("Temperature valid during hold-off");
  a_boost: assert property (s_q.cond_en && s_q.probe_en && supply_ok && dewpoint_near |=> heat_boost)
    else $error("Heating boost missing");
  a_probe_low: assert property (!supply_ok |=> !probe_heat_on && !heat_boost)
    else $error("Probe heating on low supply");
  a_probe_cfg: assert property (!s_q.probe_en || !s_q.cond_en |=> !probe_heat_on)
    else $error("Probe heating without enable");
  a_hold_purge: assert property (s_q.state == phss_pkg::ST_PURGE |=> hold_outputs)
    else $error("Outputs not held in purge");
  a_no_restart: assert property (s_q.state == phss_pkg::ST_PURGE && start_req && !tick
    |=> s_q.sec_tmr == $past(s_q.sec_tmr))
    else $error("Purge restarted by request");
  a_boot_blink: assert property (s_q.led_en && !error_in && s_q.state == phss_pkg::ST_BOOT
    |=> led_green == $past(s_q.blink) && !led_red)
    else $error("LED not blinking during power-up");
  a_cond_gate: assert property (!s_q.cond_en |=> !sensor_warm_on && !probe_heat_on && !heat_boost)
    else $error("Heating without condensation enable");
  a_warm_run: assert property (s_q.cond_en && warm_needed && s_q.state == phss_pkg::ST_IDLE
    |=> sensor_warm_on)
    else $error("Sensor warming not started");
  a_meas_back: assert property (s_q.state == phss_pkg::ST_IDLE |=> meas_valid && dp_valid && !hold_outputs)
    else $error("Outputs not released after purge");
  a_ext_store: assert property (mb_req.wr && mb_req.addr == phss_pkg::ADDR_EXT_TEMP
    |=> s_q.ext_valid && s_q.ext_temp == $past(mb_req.wdata))
    else $error("External temperature not stored");
  a_purge_stop: assert property (s_q.state == phss_pkg::ST_PURGE && tick && s_q.sec_tmr == 32'(PURGE_S - 1)
    |=> s_q.state == phss_pkg::ST_IDLE)
    else $error("Purge not ended on time");

  c_purge_run: cover property (s_q.state == phss_pkg::ST_PURGE ##1 s_q.state == phss_pkg::ST_IDLE);
  c_warm_stop: cover property ($fell(s_q.sensor_warm) ##1 s_q.hold_tmr != 32'h0000_0000);
  c_led_red: cover property (led_red);
  c_ext_temp: cover property (s_q.ext_valid && s_q.sensor_warm ##1 temp_valid);
  c_daily_purge: cover property (period_due && s_q.state == phss_pkg::ST_IDLE);

endmodule : phss_seq

`default_nettype wire

// ===== phss_dummy_guard.sv
// Intentionally empty compile unit
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== phss_host_model.sv
// Host side model: Modbus register master and purge contact
`timescale 1ns/100ps
`default_nettype none
module phss_host_model (
  // Clock
  input wire logic sys_clk,
  // Requests to the sequencer
  output var phss_pkg::phss_mb_req_t mb_req,
  output var logic mb_active,
  output var logic purge_contact,
  // Read answers
  input wire logic mb_rd_valid,
  input wire logic [15:0] mb_rdata
);
  initial
  begin
    mb_req = '0;
    mb_active = 1'b0;
    purge_contact = 1'b0;
  end

  // Released bus lines show the inverse of the last value
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    mb_req.addr = a;
    mb_req.wdata = d;
    mb_req.wr = 1'b1;
    @(posedge sys_clk);
    #1;
    mb_req.wr = 1'b0;
    mb_req.addr = ~a;
    mb_req.wdata = ~d;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
    @(posedge sys_clk);
    #1;
    mb_req.addr = a;
    mb_req.rd = 1'b1;
    @(posedge sys_clk);
    #1;
    mb_req.rd = 1'b0;
    mb_req.addr = ~a;
    ok = mb_rd_valid;
    d = mb_rdata;
  endtask : rd

  task automatic set_active(input logic v);
    @(posedge sys_clk);
    #1;
    mb_active = v;
  endtask : set_active

  // Contact closes for three cycles, then opens
  task automatic contact();
    @(posedge sys_clk);
    #1;
    purge_contact = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    purge_contact = 1'b0;
  endtask : contact
endmodule : phss_host_model
`default_nettype wire

// ===== phss_seq_tb.sv
// Self-checking testbench of the purge and heating sequencer
`timescale 1ns/100ps
`default_nettype none
module phss_seq_tb;
  localparam int CPS = 10;
  localparam int PS = 5;
  localparam int PER = 40;
  localparam int WH = 4;
  logic sys_clk, nrst, mb_rd_valid, error_in, supply_ok, warm_needed, dewpoint_near;
  logic mb_active, purge_contact, purge_heat_on, sensor_warm_on, probe_heat_on, heat_boost;
  logic meas_valid, dp_valid, temp_valid, hold_outputs, led_green, led_red, ok;
  logic [15:0] mb_rdata, d;
  phss_pkg::phss_mb_req_t mb_req;
  phss_pkg::phss_variant_t variant;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0, k;

  phss_seq #(.CLK_PER_SEC(CPS), .PURGE_S(PS), .PERIOD_S(PER), .WARM_HOLD_SEC(WH), .STARTUP_S(2),
    .COND_EN_RST(1'b0)) uut (.sys_clk(sys_clk), .nrst(nrst), .mb_req(mb_req), .mb_active(mb_active),
    .mb_rd_valid(mb_rd_valid), .mb_rdata(mb_rdata), .variant(variant), .error_in(error_in),
    .supply_ok(supply_ok), .purge_contact(purge_contact), .warm_needed(warm_needed),
    .dewpoint_near(dewpoint_near), .purge_heat_on(purge_heat_on), .sensor_warm_on(sensor_warm_on),
    .probe_heat_on(probe_heat_on), .heat_boost(heat_boost), .meas_valid(meas_valid), .dp_valid(dp_valid),
    .temp_valid(temp_valid), .hold_outputs(hold_outputs), .led_green(led_green), .led_red(led_red));

  phss_host_model host (.sys_clk(sys_clk), .mb_req(mb_req), .mb_active(mb_active),
    .purge_contact(purge_contact), .mb_rd_valid(mb_rd_valid), .mb_rdata(mb_rdata));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic await(ref logic s, input logic v, input int lim, input string nm);
    int i;
    i = 0;
    while (s !== v && i < lim)
    begin
      tick(1);
      i++;
    end
    chk(nm, v, s);
  endtask : await

  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp, input string nm);
    host.rd(a, d, ok);
    chk("rd_valid", 1'b1, ok);
    chk(nm, exp, d);
  endtask : rdchk

  task automatic do_reset(input phss_pkg::phss_variant_t v);
    variant = v;
    nrst = 1'b0;
    tick(5);
    chk("outputs in reset", 16'h0000, {purge_heat_on, meas_valid, led_green, led_red, probe_heat_on});
    nrst = 1'b1;
  endtask : do_reset

  task automatic t_startup();
    rdchk(phss_pkg::ADDR_CONFIG, 16'h0001, "config reset");
    rdchk(phss_pkg::ADDR_EXT_TEMP, phss_pkg::EXT_TEMP_RST, "ext temp reset");
    await(purge_heat_on, 1'b1, 40, "startup purge");
    t0 = cyc;
    tick(3);
    chk("purge outputs", 16'h0001, {meas_valid, dp_valid, temp_valid, hold_outputs});
    host.wr(phss_pkg::ADDR_COMMAND, 16'h0001);
    host.contact();
    await(purge_heat_on, 1'b0, 80, "purge end");
    chk("purge not extended", 1'b1, cyc - t0 <= PS * CPS + 2);
    await(meas_valid, 1'b1, 2, "meas restored");
  endtask : t_startup

  task automatic t_led();
    await(led_green, 1'b1, 3, "green ready");
    k = 0;
    repeat (30)
    begin
      tick(1);
      k += (led_green === 1'b1 && led_red === 1'b0);
    end
    chk("steady green", 16'h001E, 16'(k));
    error_in = 1'b1;
    tick(2);
    chk("red on error", 2'b01, {led_green, led_red});
    error_in = 1'b0;
    host.set_active(1'b1);
    k = 0;
    repeat (40)
    begin
      d[0] = led_green;
      tick(1);
      k += (led_green !== d[0]);
    end
    chk("blink during traffic", 1'b1, k >= 3);
    host.set_active(1'b0);
    host.wr(phss_pkg::ADDR_CONFIG, 16'h0000);
    error_in = 1'b1;
    tick(2);
    chk("led disabled", 2'b00, {led_green, led_red});
    error_in = 1'b0;
    host.wr(phss_pkg::ADDR_CONFIG, 16'h0001);
  endtask : t_led

  task automatic t_manual();
    host.wr(phss_pkg::ADDR_COMMAND, 16'h0001);
    await(purge_heat_on, 1'b1, 2, "command purge");
    t0 = cyc;
    await(purge_heat_on, 1'b0, 80, "purge end");
    chk("purge length", 1'b1, cyc - t0 >= (PS - 1) * CPS && cyc - t0 <= PS * CPS + 2);
    host.contact();
    await(purge_heat_on, 1'b1, 2, "contact purge");
    await(purge_heat_on, 1'b0, 80, "purge end");
  endtask : t_manual

  task automatic t_warm();
    warm_needed = 1'b1;
    tick(3);
    chk("warm while disabled", 1'b0, sensor_warm_on);
    host.wr(phss_pkg::ADDR_CONFIG, 16'h0003);
    await(sensor_warm_on, 1'b1, 3, "sensor warming");
    tick(2);
    chk("valid while warming", 2'b01, {temp_valid, dp_valid});
    host.wr(phss_pkg::ADDR_EXT_TEMP, 16'h1A2B);
    rdchk(phss_pkg::ADDR_EXT_TEMP, 16'h1A2B, "ext temp readback");
    await(temp_valid, 1'b1, 3, "temp with ext");
    host.rd(phss_pkg::ADDR_STATUS, d, ok);
    chk("status ext and warm", 16'h0084, d & 16'h0084);
    host.wr(phss_pkg::ADDR_COMMAND, 16'h0002);
    await(temp_valid, 1'b0, 3, "ext cleared");
    warm_needed = 1'b0;
    await(sensor_warm_on, 1'b0, 3, "warming stops");
    t0 = cyc;
    await(temp_valid, 1'b1, WH * CPS + 5, "temp after hold");
    chk("hold length", 1'b1, cyc - t0 >= (WH - 1) * CPS);
  endtask : t_warm

  task automatic t_probe();
    tick(3);
    chk("probe default off", 1'b0, probe_heat_on);
    host.wr(phss_pkg::ADDR_CONFIG, 16'h0007);
    await(probe_heat_on, 1'b1, 3, "probe heating on");
    dewpoint_near = 1'b1;
    await(heat_boost, 1'b1, 3, "heat boost");
    supply_ok = 1'b0;
    await(probe_heat_on, 1'b0, 3, "low supply");
    supply_ok = 1'b1;
    dewpoint_near = 1'b0;
    host.wr(phss_pkg::ADDR_CONFIG, 16'h0001);
    rdchk(16'h0123, 16'h0000, "unmapped read");
    host.wr(phss_pkg::ADDR_STATUS, 16'hFFFF);
    host.rd(phss_pkg::ADDR_STATUS, d, ok);
    chk("status read only", 16'h0000, d & 16'hFF8E);
  endtask : t_probe

  task automatic t_variants();
    do_reset(phss_pkg::VAR_PURGE_DAILY);
    host.wr(phss_pkg::ADDR_CONFIG, 16'h0000);
    await(purge_heat_on, 1'b1, 40, "first purge");
    await(purge_heat_on, 1'b0, 80, "purge end");
    await(purge_heat_on, 1'b1, PER * CPS, "daily purge");
    await(purge_heat_on, 1'b0, 80, "purge end");
    do_reset(phss_pkg::VAR_OIL);
    k = 0;
    t0 = 0;
    repeat (60)
    begin
      tick(1);
      k += (purge_heat_on !== 1'b0);
      t0 += (led_green === 1'b0);
    end
    chk("boot blink", 1'b1, t0 >= 5 && t0 <= 12);
    host.wr(phss_pkg::ADDR_COMMAND, 16'h0001);
    host.contact();
    tick(3);
    chk("oil never purges", 16'h0000, 16'(k + (purge_heat_on !== 1'b0)));
  endtask : t_variants

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  initial
  begin
    nrst = 1'b0;
    variant = phss_pkg::VAR_PURGE_ONCE;
    error_in = 1'b0;
    supply_ok = 1'b1;
    warm_needed = 1'b0;
    dewpoint_near = 1'b0;
    do_reset(phss_pkg::VAR_PURGE_ONCE);
    t_startup();
    t_led();
    t_manual();
    t_warm();
    t_probe();
    t_variants();
    results();
  end

  // Watchdog well past the expected run of roughly a thousand cycles
  initial
  begin
    #400000;
    mismatches++;
    results();
  end
endmodule : phss_seq_tb
`default_nettype wire
